// File: hw/acu_defines.svh
// Purpose: Constants of the axis command unit: offsets, fields, codes, times
// Assumes: APB byte addresses, 32-bit data, pclk at 10 MHz
// Notes:   Definitions only
`ifndef ACU_DEFINES_SVH
`define ACU_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ACU_OFS_CTRL      8'h00
`define ACU_OFS_ACC_TIME  8'h04
`define ACU_OFS_DEC_TIME  8'h08
`define ACU_OFS_NEW_SPEED 8'h0c
`define ACU_OFS_FLAGS     8'h10
`define ACU_OFS_ERR_CODE  8'h14
`define ACU_OFS_FEED      8'h18
`define ACU_OFS_SPEED     8'h1c
`define ACU_OFS_STATUS    8'h20

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define ACU_CTRL_RESTORE  0
`define ACU_CTRL_HALT     1
`define ACU_CTRL_SPDCHG   2
`define ACU_CTRL_START    3
`define ACU_CTRL_USE      4
`define ACU_CTRL_BADOPND  5

// ----------------------------------------------------------------------
// Flag register fields
// ----------------------------------------------------------------------
`define ACU_FLG_BUSY      0
`define ACU_FLG_DONE      1
`define ACU_FLG_OPERR     2
`define ACU_FLG_AXERR     3

// ----------------------------------------------------------------------
// Axis operation status values
// ----------------------------------------------------------------------
`define ACU_ST_STANDBY    8'h00
`define ACU_ST_STOPPED    8'h01
`define ACU_ST_RUNNING    8'h02
`define ACU_ST_DEC_HALT   8'h07
`define ACU_ST_DEC_JOG    8'h08
`define ACU_ST_ANALYZING  8'h0b
`define ACU_ST_ERROR      8'hff

// ----------------------------------------------------------------------
// Error codes (decimal 4101, 4116, 1102, 2049)
// ----------------------------------------------------------------------
`define ACU_OPERR_OPERAND 16'h1005
`define ACU_OPERR_NOUSE   16'h1014
`define ACU_AXERR_HALT_ON 16'h044e
`define ACU_AXERR_RESTORE 16'h0801

// ----------------------------------------------------------------------
// Limits and times
// ----------------------------------------------------------------------
`define ACU_SPEED_MAX     32'h00030d40
`define ACU_TIME_MAX      16'h7fff
`define ACU_CLK_NS        100
`define ACU_MS_NS         1000000
`define ACU_MS_CYCLES     (`ACU_MS_NS / `ACU_CLK_NS)
`define ACU_ABS_PAIRS     16
`define ACU_ABS_TIMEOUT   1000

`endif

// File: hw/acu_pkg.sv
// Purpose: Types shared by the axis command unit
// Assumes: Nothing beyond the defines header
// Notes:   State encodings written out
package acu_pkg;
    typedef enum logic [1:0] {
        ACU_RX_IDLE = 2'b00,
        ACU_RX_REQ  = 2'b01,
        ACU_RX_REL  = 2'b10
    } acu_rx_state_t;
endpackage

// File: hw/acu_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
module acu_sync #(
    parameter int WIDTH = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta;

    // ------------------------------------------------------------------
    // Two flip-flops per bit
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // acu_sync

// File: hw/acu_abs_rx.sv
// Purpose: Absolute position handshake with the servo amplifier
// Assumes: Ready and data bits already synchronised
// Notes:   Two bits per request, low pair first
`timescale 1ns/1ps
`include "acu_defines.svh"
module acu_abs_rx
    import acu_pkg::*;
#(
    parameter int PAIRS = `ACU_ABS_PAIRS,
    parameter int TIMEOUT = `ACU_ABS_TIMEOUT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic data_bit0,
    input wire logic data_bit1,
    input wire logic data_ready,
    output logic servo_on,
    output logic xfer_mode,
    output logic request,
    output logic done,
    output logic fail,
    output logic [2*PAIRS-1:0] position
);
    initial begin
        if (PAIRS < 1 || PAIRS > 16 || TIMEOUT < 1 || TIMEOUT > 65535)
            $error("acu_abs_rx: unsupported parameters");
    end

    acu_rx_state_t state, next_state;
    logic [4:0] pairs, next_pairs;
    logic [15:0] wait_cnt, next_wait_cnt;
    logic next_servo_on, next_xfer_mode, next_request, next_done, next_fail;
    logic [2*PAIRS-1:0] next_position;

    // ------------------------------------------------------------------
    // Handshake sequencing
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_pairs = pairs;
        next_wait_cnt = wait_cnt + 16'h0001;
        next_servo_on = servo_on;
        next_xfer_mode = xfer_mode;
        next_request = request;
        next_done = 1'b0;
        next_fail = 1'b0;
        next_position = position;
        unique case (state)
            ACU_RX_IDLE: begin
                next_wait_cnt = 16'h0000;
                if (start) begin
                    next_servo_on = 1'b1;
                    next_xfer_mode = 1'b1;
                    next_request = 1'b1;
                    next_pairs = 5'h00;
                    next_state = ACU_RX_REQ;
                end
            end
            ACU_RX_REQ: begin
                if (data_ready) begin
                    // Shift in two bits from the top, low pair ends lowest
                    next_position = {data_bit1, data_bit0,
                                     position[2*PAIRS-1:2]};
                    next_pairs = pairs + 5'h01;
                    next_request = 1'b0;
                    next_wait_cnt = 16'h0000;
                    next_state = ACU_RX_REL;
                end
            end
            ACU_RX_REL: begin
                if (!data_ready) begin
                    next_wait_cnt = 16'h0000;
                    if (pairs == 5'(PAIRS)) begin
                        next_xfer_mode = 1'b0;
                        next_done = 1'b1;
                        next_state = ACU_RX_IDLE;
                    end else begin
                        next_request = 1'b1;
                        next_state = ACU_RX_REQ;
                    end
                end
            end
            default: next_state = ACU_RX_IDLE;
        endcase
        // Silent amplifier ends the transfer with a failure
        if (state != ACU_RX_IDLE && wait_cnt == 16'(TIMEOUT)) begin
            next_xfer_mode = 1'b0;
            next_request = 1'b0;
            next_fail = 1'b1;
            next_done = 1'b0;
            next_state = ACU_RX_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // Handshake registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ACU_RX_IDLE;
            pairs <= 5'h00;
            wait_cnt <= 16'h0000;
            servo_on <= 1'b0;
            xfer_mode <= 1'b0;
            request <= 1'b0;
            done <= 1'b0;
            fail <= 1'b0;
            position <= '0;
        end else begin
            state <= next_state;
            pairs <= next_pairs;
            wait_cnt <= next_wait_cnt;
            servo_on <= next_servo_on;
            xfer_mode <= next_xfer_mode;
            request <= next_request;
            done <= next_done;
            fail <= next_fail;
            position <= next_position;
        end
    end
endmodule // acu_abs_rx

// File: hw/acu_axis.sv
// Purpose: Axis command unit: restore, halt, speed change over APB
// Assumes: pclk at 10 MHz, servo pins asynchronous
// Notes:   Zero-wait APB slave, one access cycle
//
// Notes on behaviour
// - Servo gives bit0, bit1 and ready inputs
// - Device drives servo-on, transfer mode, request
// - Accepted restore sets busy flag
// - Restored position goes to feed value
// - Restore success clears busy, sets complete
// - Complete flag clears at next axis start
// - Halt ignored while restore runs
// - Restore error leaves complete flag clear
// - Operation error sets flag, stores code
// - Axis not in use gives code 4116
// - Halt decelerates axis to stop
// - Halt ignored in statuses 0,1,-1,7,8,11
// - Start with halt active fails, code 1102
// - Halt stop leaves complete flag clear
// - Speed change uses two times, new speed
// - Speed above range runs at limit
// - Speed change ignored in same statuses
// - Speed change acts on rising edge
`timescale 1ns/1ps
`include "acu_defines.svh"
module acu_axis
    import acu_pkg::*;
#(
    parameter int MS_CYCLES = `ACU_MS_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic servo_data_bit0,
    input wire logic servo_data_bit1,
    input wire logic servo_data_ready,
    output logic servo_on,
    output logic servo_xfer_mode,
    output logic servo_request
);
    initial begin
        if (MS_CYCLES < 1 || MS_CYCLES > 65535)
            $error("acu_axis: MS_CYCLES out of range");
    end

    logic [2:0] servo_in;
    logic abs_start, abs_done, abs_fail;
    logic [31:0] abs_pos;

    // ------------------------------------------------------------------
    // Servo inputs through two flip-flops
    // ------------------------------------------------------------------
    acu_sync #(.WIDTH(3)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din({servo_data_ready, servo_data_bit1, servo_data_bit0}),
        .dout(servo_in)
    );

    acu_abs_rx #(.PAIRS(`ACU_ABS_PAIRS), .TIMEOUT(`ACU_ABS_TIMEOUT)) u_rx (
        .pclk(pclk),
        .presetn(presetn),
        .start(abs_start),
        .data_bit0(servo_in[0]),
        .data_bit1(servo_in[1]),
        .data_ready(servo_in[2]),
        .servo_on(servo_on),
        .xfer_mode(servo_xfer_mode),
        .request(servo_request),
        .done(abs_done),
        .fail(abs_fail),
        .position(abs_pos)
    );

    // State of the axis and its registers
    logic [5:0] ctrl, next_ctrl;
    logic [15:0] acc_time, next_acc_time, dec_time, next_dec_time;
    logic [31:0] new_speed, next_new_speed, speed, next_speed;
    logic [31:0] target, next_target, feed, next_feed;
    logic [7:0] status, next_status;
    logic busy, next_busy, done, next_done;
    logic operr, next_operr, axerr, next_axerr;
    logic [15:0] operr_code, next_operr_code;
    logic [15:0] axerr_code, next_axerr_code;
    logic [15:0] ms_left, next_ms_left;
    logic [15:0] tick_cnt, next_tick_cnt;
    logic ramping, next_ramping;
    logic spd_prev, next_spd_prev, next_abs_start;
    logic next_pready, next_pslverr;
    logic [31:0] next_prdata;
    logic wr, setup, mapped, quiet, tick, go_restore, go_start, spd_edge;
    logic [31:0] clamped;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    assign setup = psel && !penable;
    assign wr = psel && penable && pready && pwrite;
    assign mapped = (paddr <= `ACU_OFS_STATUS) && (paddr[1:0] == 2'b00);
    // Statuses in which halt and speed change do nothing
    assign quiet = (status == `ACU_ST_STANDBY) ||
                   (status == `ACU_ST_STOPPED) ||
                   (status == `ACU_ST_ERROR) ||
                   (status == `ACU_ST_DEC_HALT) ||
                   (status == `ACU_ST_DEC_JOG) ||
                   (status == `ACU_ST_ANALYZING);
    assign tick = (tick_cnt == 16'(MS_CYCLES - 1));
    assign go_restore = wr && (paddr == `ACU_OFS_CTRL) &&
                        pwdata[`ACU_CTRL_RESTORE];
    assign go_start = wr && (paddr == `ACU_OFS_CTRL) &&
                      pwdata[`ACU_CTRL_START];
    assign spd_edge = ctrl[`ACU_CTRL_SPDCHG] && !spd_prev;
    // Out-of-range speed runs at the limit
    assign clamped = (new_speed > `ACU_SPEED_MAX) ?
                     `ACU_SPEED_MAX : new_speed;

    // ------------------------------------------------------------------
    // Register read and bus answer
    // ------------------------------------------------------------------
    always_comb begin
        next_prdata = prdata;
        next_pready = setup;
        next_pslverr = setup && !mapped;
        if (setup) begin
            unique case (paddr)
                `ACU_OFS_CTRL: next_prdata = {26'h0, ctrl};
                `ACU_OFS_ACC_TIME: next_prdata = {16'h0, acc_time};
                `ACU_OFS_DEC_TIME: next_prdata = {16'h0, dec_time};
                `ACU_OFS_NEW_SPEED: next_prdata = new_speed;
                `ACU_OFS_FLAGS: next_prdata = {28'h0, axerr, operr, done,
                                               busy};
                `ACU_OFS_ERR_CODE: next_prdata = {axerr_code, operr_code};
                `ACU_OFS_FEED: next_prdata = feed;
                `ACU_OFS_SPEED: next_prdata = speed;
                `ACU_OFS_STATUS: next_prdata = {{24{status[7]}}, status};
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Commands, axis status and flags
    // ------------------------------------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        next_acc_time = acc_time;
        next_dec_time = dec_time;
        next_new_speed = new_speed;
        next_speed = speed;
        next_target = target;
        next_feed = feed;
        next_status = status;
        next_busy = busy;
        next_done = done;
        next_operr = operr;
        next_axerr = axerr;
        next_operr_code = operr_code;
        next_axerr_code = axerr_code;
        next_ms_left = ms_left;
        next_ramping = ramping;
        next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
        next_spd_prev = ctrl[`ACU_CTRL_SPDCHG];
        next_abs_start = 1'b0;

        // Software writes; flag clears come first so sets below win
        if (wr) begin
            unique case (paddr)
                `ACU_OFS_CTRL: begin
                    next_ctrl = pwdata[5:0];
                    next_ctrl[`ACU_CTRL_RESTORE] = 1'b0;
                    next_ctrl[`ACU_CTRL_START] = 1'b0;
                end
                `ACU_OFS_ACC_TIME: next_acc_time = pwdata[15:0] &
                                                   `ACU_TIME_MAX;
                `ACU_OFS_DEC_TIME: next_dec_time = pwdata[15:0] &
                                                   `ACU_TIME_MAX;
                `ACU_OFS_NEW_SPEED: next_new_speed = pwdata;
                `ACU_OFS_FLAGS: begin
                    if (pwdata[`ACU_FLG_OPERR])
                        next_operr = 1'b0;
                    if (pwdata[`ACU_FLG_AXERR])
                        next_axerr = 1'b0;
                end
                default: ;
            endcase
        end

        // Absolute restore request
        // Command qualifiers come from the word that carries the command
        if (go_restore) begin
            if (!pwdata[`ACU_CTRL_USE]) begin
                next_operr = 1'b1;
                next_operr_code = `ACU_OPERR_NOUSE;
            end else if (pwdata[`ACU_CTRL_BADOPND]) begin
                next_operr = 1'b1;
                next_operr_code = `ACU_OPERR_OPERAND;
            end else if (!busy) begin
                next_abs_start = 1'b1;
                next_busy = 1'b1;
                next_done = 1'b0;
                next_status = `ACU_ST_ANALYZING;
            end
        end

        // Positioning start
        if (go_start) begin
            if (!pwdata[`ACU_CTRL_USE]) begin
                next_operr = 1'b1;
                next_operr_code = `ACU_OPERR_NOUSE;
            end else if (pwdata[`ACU_CTRL_HALT]) begin
                next_axerr = 1'b1;
                next_axerr_code = `ACU_AXERR_HALT_ON;
            end else if (!busy) begin
                next_busy = 1'b1;
                next_done = 1'b0;
                next_status = `ACU_ST_RUNNING;
                next_speed = clamped;
                next_target = clamped;
            end
        end

        // Halt level, not seen while restoring or in a quiet status
        if (ctrl[`ACU_CTRL_HALT] && !quiet) begin
            if (!ctrl[`ACU_CTRL_USE]) begin
                next_operr = 1'b1;
                next_operr_code = `ACU_OPERR_NOUSE;
            end else begin
                next_status = `ACU_ST_DEC_HALT;
                next_target = 32'h0000_0000;
                next_ms_left = dec_time;
                next_ramping = 1'b1;
            end
        end

        // Speed change on the rising edge of its condition
        if (spd_edge && !quiet && status != `ACU_ST_DEC_HALT) begin
            if (!ctrl[`ACU_CTRL_USE]) begin
                next_operr = 1'b1;
                next_operr_code = `ACU_OPERR_NOUSE;
            end else if (ctrl[`ACU_CTRL_BADOPND]) begin
                next_operr = 1'b1;
                next_operr_code = `ACU_OPERR_OPERAND;
            end else begin
                next_target = clamped;
                next_ms_left = (clamped < speed) ? dec_time : acc_time;
                next_ramping = 1'b1;
            end
        end

        // Millisecond timer reaches the new speed after the set time
        if (ramping && tick) begin
            if (ms_left != 16'h0000) begin
                next_ms_left = ms_left - 16'h0001;
            end else begin
                next_ramping = 1'b0;
                next_speed = target;
                if (status == `ACU_ST_DEC_HALT) begin
                    next_status = `ACU_ST_STOPPED;
                    next_busy = 1'b0;
                    next_done = 1'b0;
                end
            end
        end

        // End of the absolute transfer
        if (abs_done) begin
            next_feed = abs_pos;
            next_busy = 1'b0;
            next_done = 1'b1;
            next_status = `ACU_ST_STANDBY;
        end else if (abs_fail) begin
            next_busy = 1'b0;
            next_done = 1'b0;
            next_axerr = 1'b1;
            next_axerr_code = `ACU_AXERR_RESTORE;
            next_status = `ACU_ST_ERROR;
        end
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            ctrl <= 6'h00;
            acc_time <= 16'h0000;
            dec_time <= 16'h0000;
            new_speed <= 32'h0000_0000;
            speed <= 32'h0000_0000;
            target <= 32'h0000_0000;
            feed <= 32'h0000_0000;
            status <= `ACU_ST_STANDBY;
            busy <= 1'b0;
            done <= 1'b0;
            operr <= 1'b0;
            axerr <= 1'b0;
            operr_code <= 16'h0000;
            axerr_code <= 16'h0000;
            ms_left <= 16'h0000;
            tick_cnt <= 16'h0000;
            ramping <= 1'b0;
            spd_prev <= 1'b0;
            abs_start <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            ctrl <= next_ctrl;
            acc_time <= next_acc_time;
            dec_time <= next_dec_time;
            new_speed <= next_new_speed;
            speed <= next_speed;
            target <= next_target;
            feed <= next_feed;
            status <= next_status;
            busy <= next_busy;
            done <= next_done;
            operr <= next_operr;
            axerr <= next_axerr;
            operr_code <= next_operr_code;
            axerr_code <= next_axerr_code;
            ms_left <= next_ms_left;
            tick_cnt <= next_tick_cnt;
            ramping <= next_ramping;
            spd_prev <= next_spd_prev;
            abs_start <= next_abs_start;
        end
    end
endmodule // acu_axis

// File: tb/acu_props.sv
// Purpose: Port checks of the axis command unit
// Assumes: One clock domain, zero-wait bus slave
// Notes: Bound to acu_axis
`timescale 1ns/1ps
module acu_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic servo_data_bit0,
    input wire logic servo_data_bit1,
    input wire logic servo_data_ready,
    input wire logic servo_on,
    input wire logic servo_xfer_mode,
    input wire logic servo_request
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Setup phase of a bus transfer
    sequence s_setup; psel && !penable; endsequence
    sequence s_bad; paddr[1:0] != 2'b00 || paddr > 8'h20; endsequence
    property p_rdy; s_setup |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready late");
    property p_rdy_in; pready |-> psel && penable; endproperty
    a_rdy_in: assert property (p_rdy_in) else $error("stray ready");
    property p_err; s_setup ##0 s_bad |=> pslverr; endproperty
    a_err: assert property (p_err) else $error("no error");
    property p_rd0; s_setup ##0 s_bad ##0 !pwrite |=> prdata == 0;
    endproperty
    a_rd0: assert property (p_rd0) else $error("refused data");
    property p_on; servo_on |=> servo_on; endproperty
    a_on: assert property (p_on) else $error("servo on lost");
    property p_rise; $rose(servo_xfer_mode) |-> servo_on && servo_request;
    endproperty
    a_rise: assert property (p_rise) else $error("bad start");
    property p_req; servo_request |-> servo_xfer_mode; endproperty
    a_req: assert property (p_req) else $error("stray request");
    property p_drop; servo_request && servo_data_ready |-> ##[1:4]
        !servo_request; endproperty
    a_drop: assert property (p_drop) else $error("request held");
endmodule // acu_props
bind acu_axis acu_props acu_props_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .servo_data_bit0(servo_data_bit0), .servo_data_bit1(servo_data_bit1),
    .servo_data_ready(servo_data_ready), .servo_on(servo_on),
    .servo_xfer_mode(servo_xfer_mode), .servo_request(servo_request));

// File: tb/acu_servo_model.sv
// Purpose: Servo amplifier side of the position handshake
// Assumes: Answers after dly cycles; mute never answers
// Notes: Data lines show inverted values while not ready
`timescale 1ns/1ps
module acu_servo_model (
    input wire logic pclk,
    input wire logic xfer,
    input wire logic req,
    input wire logic mute,
    input wire logic [7:0] dly,
    input wire logic [31:0] pos,
    output logic b0,
    output logic b1,
    output logic rdy
);
    int idx = 0;
    int cnt = 0;
    initial {b1, b0, rdy} = 3'b000;
    // Ready rises only while requested and falls after request drops, pairs low first
    always @(posedge pclk) begin
        cnt <= cnt + 1;
        if (!xfer) begin
            idx <= 0;
            rdy <= 1'b0;
        end else if (req && !rdy && !mute && cnt >= dly) begin
            {b1, b0} <= pos[2*idx +: 2];
            rdy <= 1'b1;
            cnt <= 0;
        end else if (!req && rdy && cnt >= dly) begin
            {b1, b0} <= ~{b1, b0};
            rdy <= 1'b0;
            idx <= idx + 1;
            cnt <= 0;
        end
    end
endmodule // acu_servo_model

// File: tb/tb_top.sv
// Purpose: Self-checking bench of the axis command unit
// Assumes: MS_CYCLES of 4 keeps the times short
// Notes: All commands go through the bus tasks
`timescale 1ns/1ps
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00, dly = 8'h02;
    logic [31:0] pwdata = 0, prdata, r, pos = 32'ha5c31e96;
    logic pready, pslverr, b0, b1, rdy, son, xm, rq, err, mute = 0;
    int bad_count = 0, n_tests = 0, tn = 0;
    always #50 pclk = ~pclk;
    acu_axis #(.MS_CYCLES(4)) acu_axis_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .servo_data_bit0(b0), .servo_data_bit1(b1), .servo_data_ready(rdy),
        .servo_on(son), .servo_xfer_mode(xm), .servo_request(rq));
    acu_servo_model acu_servo_model_inst (.pclk(pclk), .xfer(xm), .req(rq),
        .mute(mute), .dly(dly), .pos(pos), .b0(b0), .b1(b1), .rdy(rdy));
    // One bus transfer, held until ready
    task automatic bus(input logic wr, input logic [7:0] a, logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        r = prdata;
        err = pslverr;
        if (pready !== 1'b1) bad_count++;
        {psel, penable} <= 2'b00;
    endtask
    task automatic chk(input logic [31:0] g, e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic w(input logic [7:0] a, logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic c(input logic [7:0] a, logic [31:0] e);
        bus(1'b0, a, 0);
        chk(r, e);
    endtask
    task automatic t;
        tn++;
        $display("test %0d ended", tn);
    endtask
    task automatic wait_xfer;
        int n = 0;
        repeat (4) @(posedge pclk);
        while (xm !== 1'b0 && n < 1200) begin @(posedge pclk); n++; end
        if (xm !== 1'b0) bad_count++;
        repeat (4) @(posedge pclk);
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog well above the run length
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        conclude();
    end
    // Test sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        c(8'h20, 0);
        c(8'h22, 0);
        chk(err, 1);
        c(8'h24, 0);
        w(8'h00, 32'h12);
        c(8'h20, 0);
        w(8'h00, 32'h01);
        c(8'h10, 32'h4);
        c(8'h14, 32'h1014);
        w(8'h10, 32'h4);
        w(8'h00, 32'h31);
        c(8'h14, 32'h1005);
        w(8'h10, 32'h4);
        c(8'h10, 0);
        t();
        w(8'h00, 32'h11);
        c(8'h20, 32'h0b);
        c(8'h10, 32'h1);
        w(8'h00, 32'h12);
        wait_xfer();
        c(8'h20, 0);
        c(8'h18, pos);
        chk({son, xm, rq, err}, 4'h8);
        c(8'h10, 32'h2);
        w(8'h00, 32'h1a);
        c(8'h10, 32'ha);
        bus(1'b0, 8'h14, 0);
        chk(r >> 16, 32'h044e);
        w(8'h10, 32'h8);
        t();
        w(8'h0c, 32'h493e0);
        w(8'h04, 32'h2);
        w(8'h08, 32'h3);
        w(8'h00, 32'h18);
        c(8'h20, 32'h2);
        c(8'h10, 32'h1);
        c(8'h1c, 32'h30d40);
        w(8'h0c, 32'h3e8);
        w(8'h00, 32'h14);
        repeat (20) @(posedge pclk);
        c(8'h1c, 32'h3e8);
        w(8'h0c, 32'h1388);
        repeat (20) @(posedge pclk);
        c(8'h1c, 32'h3e8);
        w(8'h00, 32'h12);
        c(8'h20, 32'h7);
        repeat (20) @(posedge pclk);
        c(8'h20, 32'h1);
        c(8'h10, 0);
        w(8'h00, 32'h14);
        repeat (20) @(posedge pclk);
        c(8'h1c, 0);
        w(8'h00, 32'h12);
        c(8'h20, 32'h1);
        t();
        mute <= 1'b1;
        w(8'h00, 32'h11);
        wait_xfer();
        c(8'h10, 32'h8);
        c(8'h20, 32'hffffffff);
        t();
        conclude();
    end
endmodule // tb_top
